// ### hw/pmdb_bank.sv
// Peripheral module-disable register bank with an AHB-Lite slave port.
// Assumes a single-master AHB-Lite bus on mclk; its hreadyout is the bus hready.
//
// Overview of operation
// - Unimplemented bit positions read as zero and ignore writes.
// - Serial register bit 6 holds serial port 5 off while set.
// - Serial register bit 5 holds serial port 4 off while set.
// - Serial register bit 4 holds serial port 3 off while set.
// - Serial register bits 6 to 0 serve serial ports 5..1 then sync ports 2, 1.
// - Serial register bit 2 holds serial port 1 off while set.
// - Serial register bit 1 holds sync serial port 2 off while set.
// - Serial register bit 0 holds sync serial port 1 off while set.
// - Implemented serial bits are read/write and clear to zero on every reset.
// - System register bits 7..0 gate sysclock, vref, detector, crc, scanner, nvm, refclk, ioc.
// - Timer register bits 7..0 gate timers 7 down to 0.
// - Waveform register bits 5, 3, 2, 1, 0 gate cwg, dsm, smt2, smt1, timer 8.
// - Analog register bits 6, 5, 3..1, 0 gate dac, adc, comparators 3..1, zero-cross.
// - Pulse register bits 6, 5 gate pwm 7, 6 and bits 4..0 capture units 5..1.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "pmdb_regs.svh"

module pmdb_bank (
    // Clock, reset, enable
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic                       clk_en,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    // System group disables
    output logic                            sysclock_off,
    output logic                            fixed_vref_off,
    output logic                            voltage_detect_off,
    output logic                            crc_unit_off,
    output logic                            mem_scanner_off,
    output logic                            nonvolatile_ctrl_off,
    output logic                            ref_clock_out_off,
    output logic                            pin_change_irq_off,
    // Timer, waveform, analog, pulse and serial disables as groups
    output logic      [7:0]                 timer_off,
    output logic                            compl_waveform_off,
    output logic                            signal_modulator_off,
    output logic                            meas_timer2_off,
    output logic                            meas_timer1_off,
    output logic                            timer8_off,
    output logic                            dac_unit_off,
    output logic                            adc_unit_off,
    output logic      [3:1]                 comparator_off,
    output logic                            zero_cross_off,
    output logic                            pulse_width7_off,
    output logic                            pulse_width6_off,
    output logic      [5:1]                 capcomp_off,
    output logic      [5:1]                 serial_off,
    output logic                            sync_serial2_off,
    output logic                            sync_serial1_off
);

    // Register storage, index order matches the offset order
    logic [7:0]                 ctrl [`PMDB_REG_COUNT];
    pmdb_pkg::pmdb_req_type     req;
    logic                       req_valid;
    logic [31:0]                next_hrdata;
    pmdb_pkg::pmdb_off_type     off;

    // Decode an address into a register index; COUNT means unmapped
    function automatic logic [2:0] reg_index(input logic [`PMDB_ADDR_BITS-1:0] a);
        if (a == `PMDB_SYSTEM_OFFSET) begin
            reg_index = 3'h0;
        end else if (a == `PMDB_TIMER_OFFSET) begin
            reg_index = 3'h1;
        end else if (a == `PMDB_WAVEFORM_OFFSET) begin
            reg_index = 3'h2;
        end else if (a == `PMDB_ANALOG_OFFSET) begin
            reg_index = 3'h3;
        end else if (a == `PMDB_PULSE_OFFSET) begin
            reg_index = 3'h4;
        end else if (a == `PMDB_SERIAL_OFFSET) begin
            reg_index = 3'h5;
        end else begin
            reg_index = 3'h6;
        end
    endfunction

    // Implemented-bit mask of each register
    function automatic logic [7:0] reg_mask(input logic [2:0] idx);
        case (idx)
            3'h0:    reg_mask = `PMDB_SYSTEM_MASK;
            3'h1:    reg_mask = `PMDB_TIMER_MASK;
            3'h2:    reg_mask = `PMDB_WAVEFORM_MASK;
            3'h3:    reg_mask = `PMDB_ANALOG_MASK;
            3'h4:    reg_mask = `PMDB_PULSE_MASK;
            3'h5:    reg_mask = `PMDB_SERIAL_MASK;
            default: reg_mask = 8'h00;
        endcase
    endfunction

    // Address phase capture; the slave is always ready, so no wait states
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_valid <= 1'b0;
            req       <= '0;
        end else if (clk_en && hready) begin
            req_valid <= hsel && htrans[1];
            req.write <= hwrite;
            req.addr  <= haddr[`PMDB_ADDR_BITS-1:0];
        end
    end

    // Write data phase; only implemented bits are stored
    // masked writes
    generate
        for (genvar i = 0; i < `PMDB_REG_COUNT; i++) begin : g_reg
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    ctrl[i] <= `PMDB_REG_RESET;
                end else if (clk_en && req_valid && req.write
                             && reg_index(req.addr) == 3'(i)) begin
                    ctrl[i] <= hwdata[7:0] & reg_mask(3'(i));
                end
            end
        end
    endgenerate

    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (hsel && htrans[1] && !hwrite) begin
            if (reg_index(haddr[`PMDB_ADDR_BITS-1:0]) != 3'h6) begin
                next_hrdata[7:0] = ctrl[reg_index(haddr[`PMDB_ADDR_BITS-1:0])]
                                   & reg_mask(reg_index(haddr[`PMDB_ADDR_BITS-1:0]));
            end
        end
    end

    // Read data registered in the address phase so hrdata is a flop output
    // A read right behind a write to the same register still sees the old byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en && hready) begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign off = '{system_off: ctrl[0], timer_off: ctrl[1], waveform_off: ctrl[2],
                   analog_off: ctrl[3], pulse_off: ctrl[4], serial_off: ctrl[5]};

    // Disable lines are flopped copies: they follow a write by one cycle
    // per-peripheral lines
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sysclock_off         <= 1'b0;
            fixed_vref_off       <= 1'b0;
            voltage_detect_off   <= 1'b0;
            crc_unit_off         <= 1'b0;
            mem_scanner_off      <= 1'b0;
            nonvolatile_ctrl_off <= 1'b0;
            ref_clock_out_off    <= 1'b0;
            pin_change_irq_off   <= 1'b0;
            timer_off            <= 8'h00;
        end else if (clk_en) begin
            {sysclock_off, fixed_vref_off, voltage_detect_off, crc_unit_off,
             mem_scanner_off, nonvolatile_ctrl_off, ref_clock_out_off,
             pin_change_irq_off} <= off.system_off;
            timer_off            <= off.timer_off;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            compl_waveform_off   <= 1'b0;
            signal_modulator_off <= 1'b0;
            meas_timer2_off      <= 1'b0;
            meas_timer1_off      <= 1'b0;
            timer8_off           <= 1'b0;
            dac_unit_off         <= 1'b0;
            adc_unit_off         <= 1'b0;
            comparator_off       <= 3'h0;
            zero_cross_off       <= 1'b0;
        end else if (clk_en) begin
            compl_waveform_off   <= off.waveform_off[5];
            signal_modulator_off <= off.waveform_off[3];
            meas_timer2_off      <= off.waveform_off[2];
            meas_timer1_off      <= off.waveform_off[1];
            timer8_off           <= off.waveform_off[0];
            dac_unit_off         <= off.analog_off[6];
            adc_unit_off         <= off.analog_off[5];
            comparator_off       <= off.analog_off[3:1];
            zero_cross_off       <= off.analog_off[0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pulse_width7_off <= 1'b0;
            pulse_width6_off <= 1'b0;
            capcomp_off      <= 5'h00;
            serial_off       <= 5'h00;
            sync_serial2_off <= 1'b0;
            sync_serial1_off <= 1'b0;
        end else if (clk_en) begin
            pulse_width7_off <= off.pulse_off[6];
            pulse_width6_off <= off.pulse_off[5];
            capcomp_off      <= off.pulse_off[4:0];
            // serial 5, serial 4, serial 3, serial 2, serial 1 in this slice
            serial_off       <= off.serial_off[6:2];
            sync_serial2_off <= off.serial_off[1];
            sync_serial1_off <= off.serial_off[0];
        end
    end

    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    serial5_follow_a: assert property (clk_en |=> serial_off[5] == $past(ctrl[5][6]))
        else $error("serial 5 line does not follow its bit");
    serial4_follow_a: assert property (clk_en |=> serial_off[4] == $past(ctrl[5][5]))
        else $error("serial 4 line does not follow its bit");
    serial3_follow_a: assert property (clk_en |=> serial_off[3] == $past(ctrl[5][4]))
        else $error("serial 3 line does not follow its bit");
    serial2_follow_a: assert property (clk_en |=> serial_off[2] == $past(ctrl[5][3]))
        else $error("serial 2 line does not follow its bit");
    serial1_follow_a: assert property (clk_en |=> serial_off[1] == $past(ctrl[5][2]))
        else $error("serial 1 line does not follow its bit");
    sync2_follow_a: assert property (clk_en |=> sync_serial2_off == $past(ctrl[5][1]))
        else $error("sync 2 line does not follow its bit");
    sync1_follow_a: assert property (clk_en |=> sync_serial1_off == $past(ctrl[5][0]))
        else $error("sync 1 line does not follow its bit");
    unimpl_zero_a: assert property (ctrl[2][7] == 1'b0 && ctrl[2][6] == 1'b0
                                    && ctrl[2][4] == 1'b0 && ctrl[3][7] == 1'b0
                                    && ctrl[3][4] == 1'b0 && ctrl[4][7] == 1'b0
                                    && ctrl[5][7] == 1'b0)
        else $error("unimplemented bit holds a one");
    serial_write_a: assert property (clk_en && req_valid && req.write
                                     && req.addr == `PMDB_SERIAL_OFFSET
                                     |=> ##1 {1'b0, serial_off, sync_serial2_off,
                                              sync_serial1_off}
                                         == ($past(hwdata[7:0], 2) & 8'h7f))
        else $error("serial write not reflected on lines");
    timer_lines_a: assert property (clk_en |=> timer_off == $past(ctrl[1]))
        else $error("timer lines do not follow register");
    sysclk_line_a: assert property (clk_en |=> sysclock_off == $past(ctrl[0][7]))
        else $error("sysclock line does not follow bit 7");
    waveform_line_a: assert property (clk_en |=> compl_waveform_off == $past(ctrl[2][5]))
        else $error("waveform line does not follow bit 5");
    dac_line_a: assert property (clk_en |=> dac_unit_off == $past(ctrl[3][6]))
        else $error("dac line does not follow bit 6");
    pwm7_line_a: assert property (clk_en |=> pulse_width7_off == $past(ctrl[4][6]))
        else $error("pwm 7 line does not follow bit 6");
    always_ready_a: assert property (hreadyout && !hresp)
        else $error("slave inserted a wait or error");

    // Group checks: the system group whole, the others without the bits checked above; a swapped bit inside a group shows here
    system_lines_a: assert property (clk_en |=> {sysclock_off, fixed_vref_off,
                                                 voltage_detect_off, crc_unit_off,
                                                 mem_scanner_off, nonvolatile_ctrl_off,
                                                 ref_clock_out_off, pin_change_irq_off}
                                                == $past(ctrl[0]))
        else $error("system lines do not follow register");
    waveform_rest_a: assert property (clk_en |=> {signal_modulator_off, meas_timer2_off,
                                                  meas_timer1_off, timer8_off}
                                                 == $past(ctrl[2][3:0]))
        else $error("waveform lines do not follow bits 3 to 0");
    analog_rest_a: assert property (clk_en |=> {adc_unit_off, comparator_off,
                                                zero_cross_off}
                                               == $past({ctrl[3][5], ctrl[3][3:0]}))
        else $error("analog lines do not follow their bits");
    pulse_rest_a: assert property (clk_en |=> {pulse_width6_off, capcomp_off}
                                              == $past(ctrl[4][5:0]))
        else $error("pulse lines do not follow bits 5 to 0");
    // Stored bytes after a write, masked to the implemented bits
    timer_write_a: assert property (clk_en && req_valid && req.write
                                    && reg_index(req.addr) == 3'h1
                                    |=> ctrl[1] == $past(hwdata[7:0]))
        else $error("timer write not stored in full");
    write_mask_a: assert property (clk_en && req_valid && req.write
                                   && reg_index(req.addr) == 3'h3
                                   |=> ctrl[3] == ($past(hwdata[7:0]) & `PMDB_ANALOG_MASK))
        else $error("analog write kept an unimplemented bit");
    unmapped_write_a: assert property (clk_en && req_valid && req.write
                                       && reg_index(req.addr) == 3'h6
                                       |=> $stable(ctrl[0]) && $stable(ctrl[1])
                                           && $stable(ctrl[2]) && $stable(ctrl[3])
                                           && $stable(ctrl[4]) && $stable(ctrl[5]))
        else $error("write to an unmapped address changed a register");
    read_upper_a: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    read_serial_a: assert property (clk_en && hready && hsel && htrans[1] && !hwrite
                                    && haddr[`PMDB_ADDR_BITS-1:0] == `PMDB_SERIAL_OFFSET
                                    |=> hrdata[7:0] == $past(ctrl[5]))
        else $error("serial read data differs from register");
    unmapped_read_a: assert property (clk_en && hready && hsel && htrans[1] && !hwrite
                                      && reg_index(haddr[`PMDB_ADDR_BITS-1:0]) == 3'h6
                                      |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    idle_read_zero_a: assert property (clk_en && hready && !(hsel && htrans[1] && !hwrite)
                                       |=> hrdata == 32'h0000_0000)
        else $error("read data not cleared outside a read");

    // Low enable must hold the serial register, serial and timer lines, bus side included
    freeze_hold_a: assert property (!clk_en |=> $stable(ctrl[5]) && $stable(serial_off)
                                                && $stable(timer_off) && $stable(hrdata))
        else $error("state moved while the clock enable was low");
    // Reset is a level: two sampled edges in reset before the cleared state is checked
    reset_clear_a: assert property (@(posedge mclk) disable iff (1'b0)
                                    !resetn ##1 !resetn |-> ctrl[5] == `PMDB_REG_RESET
                                    && serial_off == 5'h00 && hrdata == 32'h0000_0000)
        else $error("reset left a register or line set");

    serial_write_c: cover property (clk_en && req_valid && req.write
                                    && req.addr == `PMDB_SERIAL_OFFSET);
    read_hit_c: cover property (hsel && htrans[1] && !hwrite && hready
                                && haddr[11:0] == `PMDB_TIMER_OFFSET);
    unmapped_c: cover property (hsel && htrans[1] && hready
                                && reg_index(haddr[11:0]) == 3'h6);
    all_serial_off_c: cover property (serial_off == 5'h1f);
    freeze_c: cover property (!clk_en && hsel && htrans[1]
                              && hready);

endmodule

// ### hw/pmdb_regs.svh
// Register offsets, field masks and reset values of the module-disable bank.
// Assumes inclusion by the package, the bank module and its bench.
`ifndef PMDB_REGS_SVH
`define PMDB_REGS_SVH

`define PMDB_SYSTEM_OFFSET   12'h000
`define PMDB_TIMER_OFFSET    12'h004
`define PMDB_WAVEFORM_OFFSET 12'h008
`define PMDB_ANALOG_OFFSET   12'h00c
`define PMDB_PULSE_OFFSET    12'h010
`define PMDB_SERIAL_OFFSET   12'h014

`define PMDB_SYSTEM_MASK     8'hff
`define PMDB_TIMER_MASK      8'hff
`define PMDB_WAVEFORM_MASK   8'h2f
`define PMDB_ANALOG_MASK     8'h6f
`define PMDB_PULSE_MASK      8'h7f
`define PMDB_SERIAL_MASK     8'h7f

`define PMDB_REG_RESET       8'h00
`define PMDB_REG_COUNT       6
`define PMDB_ADDR_BITS       12

`endif

// ### hw/pmdb_pkg.sv
// Types used by the module-disable bank; its bench does not import them.
// Assumes pmdb_regs.svh is on the include path.
`include "pmdb_regs.svh"

package pmdb_pkg;

    // One AHB-Lite address phase as captured by the slave
    typedef struct packed {
        logic                         write;
        logic [`PMDB_ADDR_BITS-1:0]   addr;
    } pmdb_req_type;

    // Per-peripheral disable lines, grouped by register
    typedef struct packed {
        logic [7:0] system_off;
        logic [7:0] timer_off;
        logic [7:0] waveform_off;
        logic [7:0] analog_off;
        logic [7:0] pulse_off;
        logic [7:0] serial_off;
    } pmdb_off_type;

endpackage

// ### sim/tb_peripheral_module_disable_bank.sv
// Self-checking bench for the module-disable bank, driving its AHB-Lite port directly.
// Assumes pmdb_regs.svh on the include path and the bench as the only bus master.
`timescale 1ns/10ps
`include "pmdb_regs.svh"

module tb_peripheral_module_disable_bank;
    logic        mclk, resetn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sysclock_off, fixed_vref_off, voltage_detect_off, crc_unit_off;
    logic        mem_scanner_off, nonvolatile_ctrl_off, ref_clock_out_off, pin_change_irq_off;
    logic        compl_waveform_off, signal_modulator_off, meas_timer2_off, meas_timer1_off;
    logic        timer8_off, dac_unit_off, adc_unit_off, zero_cross_off;
    logic        pulse_width7_off, pulse_width6_off, sync_serial2_off, sync_serial1_off;
    logic [7:0]  timer_off;
    logic [3:1]  comparator_off;
    logic [5:1]  capcomp_off, serial_off;
    logic [31:0] q;
    int          errors, tests_run;
    logic [31:0] offs [6] = '{`PMDB_SYSTEM_OFFSET, `PMDB_TIMER_OFFSET, `PMDB_WAVEFORM_OFFSET,
                              `PMDB_ANALOG_OFFSET, `PMDB_PULSE_OFFSET, `PMDB_SERIAL_OFFSET};
    // Implemented bits per register, worked out from the bit tables
    logic [7:0]  masks [6] = '{8'hff, 8'hff, 8'h2f, 8'h6f, 8'h7f, 8'h7f};
    logic [7:0]  zeros [6] = '{default: 8'h00};

    // The single slave's hreadyout closes the bus hready loop
    pmdb_bank u_pmdb_bank (.mclk, .resetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sysclock_off,
        .fixed_vref_off, .voltage_detect_off, .crc_unit_off, .mem_scanner_off,
        .nonvolatile_ctrl_off, .ref_clock_out_off, .pin_change_irq_off, .timer_off,
        .compl_waveform_off, .signal_modulator_off, .meas_timer2_off, .meas_timer1_off,
        .timer8_off, .dac_unit_off, .adc_unit_off, .comparator_off, .zero_cross_off,
        .pulse_width7_off, .pulse_width6_off, .capcomp_off, .serial_off,
        .sync_serial2_off, .sync_serial1_off);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Samples hready and read data at the rising edge, before the slave's flops move
    task automatic wait_ready(output logic [31:0] rd);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) begin
                rd = hrdata;
                break;
            end
        end
        if (i == 20) begin
            errors++;
            conclude();
        end
    endtask

    // Entered just after a rising edge; leaves just after the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready(rd);
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready(rd);
    endtask

    task automatic check_lines(input logic [7:0] e [6]);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({sysclock_off, fixed_vref_off, voltage_detect_off, crc_unit_off,
               mem_scanner_off, nonvolatile_ctrl_off, ref_clock_out_off,
               pin_change_irq_off}, e[0], "system");
        check(timer_off, e[1], "timer");
        check({compl_waveform_off, signal_modulator_off, meas_timer2_off, meas_timer1_off,
               timer8_off}, {e[2][5], e[2][3:0]}, "waveform");
        check({dac_unit_off, adc_unit_off, comparator_off, zero_cross_off},
              {e[3][6:5], e[3][3:0]}, "analog");
        check({pulse_width7_off, pulse_width6_off, capcomp_off}, e[4][6:0], "pulse");
        check({serial_off, sync_serial2_off, sync_serial1_off}, e[5][6:0], "serial");
        @(posedge mclk);
    endtask

    task automatic read_all(input logic [7:0] e [6]);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, offs[i], 32'h0, q);
            check(q, {24'h0, e[i]}, "readback");
        end
    endtask

    task automatic t_ones();
        for (int i = 0; i < 6; i++)
            bus(1'b1, offs[i], 32'hffffffff, q);
        read_all(masks);
        check_lines(masks);
        for (int i = 0; i < 6; i++)
            bus(1'b1, offs[i], 32'h0, q);
        check_lines(zeros);
        $display("test all_ones done");
    endtask

    task automatic t_serial();
        logic [7:0] e;
        for (int b = 0; b < 8; b++) begin
            e = (8'h01 << b) & 8'h7f;
            bus(1'b1, offs[5], {24'h0, 8'h01 << b}, q);
            bus(1'b0, offs[5], 32'h0, q);
            check(q, {24'h0, e}, "serial readback");
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            check(serial_off[5], e[6], "serial5");
            check(serial_off[4], e[5], "serial4");
            check(serial_off[3], e[4], "serial3");
            check(serial_off[2], e[3], "serial2");
            check(serial_off[1], e[2], "serial1");
            check(sync_serial2_off, e[1], "sync2");
            check(sync_serial1_off, e[0], "sync1");
            @(posedge mclk);
        end
        $display("test serial_walk done");
    endtask

    task automatic t_unmapped();
        bus(1'b1, 32'h018, 32'hff, q);
        bus(1'b1, 32'hffc, 32'hff, q);
        bus(1'b0, 32'h018, 32'h0, q);
        check(q, 32'h0, "unmapped read");
        check(hresp, 1'b0, "okay response");
        read_all(zeros);
        $display("test unmapped done");
    endtask

    task automatic t_midreset();
        for (int i = 0; i < 6; i++)
            bus(1'b1, offs[i], 32'hff, q);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        check_lines(zeros);
        read_all(zeros);
        $display("test mid_reset done");
    endtask

    task automatic t_freeze();
        bus(1'b1, offs[5], 32'h41, q);
        repeat (2) @(posedge mclk);
        clk_en <= 1'b0;
        bus(1'b1, offs[5], 32'h00, q);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({serial_off, sync_serial2_off, sync_serial1_off}, 7'h41, "frozen lines");
        @(posedge mclk);
        clk_en <= 1'b1;
        @(posedge mclk);
        bus(1'b0, offs[5], 32'h0, q);
        check(q, 32'h41, "write while frozen");
        $display("test clock_enable done");
    endtask

    initial begin
        errors    = 0;
        tests_run = 0;
        resetn    = 1'b0;
        clk_en    = 1'b1;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'b010;
        hwdata    = 32'h0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        read_all(zeros);
        check_lines(zeros);
        $display("test reset done");
        t_ones();
        t_serial();
        t_unmapped();
        t_midreset();
        t_freeze();
        conclude();
    end
endmodule
